/* File: pw_defect_monitor.sv */
// Purpose: loss state, alarms, second counters, fill and AXI4-Lite registers
// Assumes: packet and tick inputs come from logic on aclk
// Notes: one pseudowire per instance
`timescale 1ns/1ns
`include "pw_defect_monitor_params.svh"
module pw_defect_monitor #(
   parameter int CLK_HZ = 20000000,
   parameter int LOSS_ALARM_CYC = (`LOSS_ALARM_MS * (CLK_HZ / 1000)) + 1
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        sec_tick,
   input  wire logic        pkt_expected,
   input  wire logic        pkt_missing,
   input  wire logic        pkt_stray,
   input  wire logic        pkt_misord_drop,
   input  wire logic        play_valid,
   input  wire logic        play_filler,
   input  wire logic        buffer_clean,
   input  wire logic [7:0]  play_octet,
   input  wire logic [31:0] play_slot_mask,
   input  wire logic [4:0]  play_slot,
   input  wire logic        play_dl_bit,
   input  wire logic [1:0]  pw_phase,
   output logic [7:0]       tdm_octet,
   output logic             tdm_valid,
   output logic             tx_rbit,
   output logic             irq
);
   logic [31:0] ctrl_q, win_q, thr_q, fill_q, irq_mask_q, irq_stat_q;
   logic [6:0]  hist_sel_q;
   logic        loss_q, excess_q, uas_q;
   logic [15:0] win_cnt_q, win_lost_q, run_miss_q, run_good_q;
   logic [31:0] loss_cyc_q;
   logic [3:0]  clean_secs_q, ses_run_q, ok_run_q;
   logic [15:0] defects_q, es_q, ses_q, uas_cnt_q, misord_q;
   logic [15:0] int_lost_q, int_secs_q;
   logic [9:0]  int_sec_q;
   logic        sec_err, sec_severe, loss_enter, loss_exit, uas_enter;
   logic [3:0]  irq_ev;
   logic        aw_q, w_q;
   logic [11:0] awaddr_q;
   logic [31:0] wdata_q;
   logic        rd_clear;
   logic        dl_force;
   logic        wr_fire;
   hist_if      hist ();

   loss_history #(.DEPTH(`HIST_DEPTH)) u_hist (
      .aclk    (aclk),
      .aresetn (aresetn),
      .h       (hist)
   );

   function automatic logic [31:0] byte_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] st);
      for (int i = 0; i < 4; i++)
         if (st[i])
            old[i*8 +: 8] = nw[i*8 +: 8];
      return old;
   endfunction

   // AXI write channel capture
   assign wr_fire = aw_q && w_q && !s_axi_bvalid;
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awaddr_q <= 12'h000;
         wdata_q <= 32'h00000000;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end
      else
      begin
         s_axi_awready <= !aw_q && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready <= !w_q && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_q <= 1'b1;
            wdata_q <= s_axi_wdata;
         end
         if (wr_fire)
         begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_q <= `REG_HIST_SEL && awaddr_q[1:0] == 2'h0) ?
                           2'h0 : 2'h2;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end

   // Software-written registers
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         ctrl_q <= 32'h00000000;
         win_q <= 32'h00000000;
         thr_q <= 32'h00000000;
         fill_q <= {24'h000000, `FILL_RESET};
         irq_mask_q <= 32'h00000000;
         hist_sel_q <= 7'h00;
      end
      else if (wr_fire)
         unique case (awaddr_q)
            `REG_CTRL:     ctrl_q <= byte_merge(ctrl_q, wdata_q, 4'hF) & 32'h00000007;
            `REG_WIN:      win_q <= wdata_q;
            `REG_THR:      thr_q <= wdata_q;
            `REG_FILL:     fill_q <= {24'h000000, wdata_q[7:0]};
            `REG_IRQ_MASK: irq_mask_q <= wdata_q & 32'h0000000F;
            `REG_HIST_SEL: hist_sel_q <= wdata_q[6:0];
            default:       ;
         endcase

   // AXI read channel
   assign rd_clear = s_axi_arvalid && s_axi_arready && s_axi_araddr == `REG_IRQ_STAT;
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'h0;
      end
      else
      begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            unique case (s_axi_araddr)
               `REG_CTRL:      s_axi_rdata <= ctrl_q;
               `REG_WIN:       s_axi_rdata <= win_q;
               `REG_THR:       s_axi_rdata <= thr_q;
               `REG_FILL:      s_axi_rdata <= fill_q;
               `REG_STAT:      s_axi_rdata <= {29'h0, uas_q, excess_q, loss_q};
               `REG_IRQ_STAT:  s_axi_rdata <= irq_stat_q;
               `REG_IRQ_MASK:  s_axi_rdata <= irq_mask_q;
               `REG_ES:        s_axi_rdata <= {16'h0000, es_q};
               `REG_SES:       s_axi_rdata <= {16'h0000, ses_q};
               `REG_UAS:       s_axi_rdata <= {16'h0000, uas_cnt_q};
               `REG_MISORD:    s_axi_rdata <= {16'h0000, misord_q};
               `REG_HIST_SEL:  s_axi_rdata <= {25'h0, hist_sel_q};
               `REG_HIST_LOST: s_axi_rdata <= {16'h0000, hist.rd_lost};
               `REG_HIST_SECS: s_axi_rdata <= {16'h0000, hist.rd_secs};
               default:
               begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= 2'h2;
               end
            endcase
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end

   // Loss window and runs; stray packets are ignored here
   assign loss_enter = !loss_q && pkt_expected && !pkt_stray &&
      ((pkt_missing && 16'(run_miss_q + 16'h1) >= win_q[31:24] && win_q[31:24] != 8'h0) ||
       (win_cnt_q == win_q[15:0] && 16'(win_lost_q * 16'd100) > 16'(win_q[23:16] * win_q[15:0])));
   assign loss_exit = loss_q && play_valid &&
      ((!play_filler && 16'(run_good_q + 16'h1) >= thr_q[31:16]) || buffer_clean);
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         loss_q <= 1'b0;
         win_cnt_q <= 16'h0;
         win_lost_q <= 16'h0;
         run_miss_q <= 16'h0;
         run_good_q <= 16'h0;
      end
      else
      begin
         if (pkt_expected && !pkt_stray)
         begin
            run_miss_q <= pkt_missing ? 16'(run_miss_q + 16'h1) : 16'h0;
            win_cnt_q <= (win_cnt_q >= win_q[15:0]) ? 16'h1 : 16'(win_cnt_q + 16'h1);
            win_lost_q <= (win_cnt_q >= win_q[15:0]) ? 16'(pkt_missing) :
                          16'(win_lost_q + 16'(pkt_missing));
         end
         if (play_valid)
            run_good_q <= play_filler ? 16'h0 : 16'(run_good_q + 16'h1);
         if (loss_enter)
            loss_q <= 1'b1;
         else if (loss_exit)
            loss_q <= 1'b0;
      end

   // Excessive-loss alarm
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         loss_cyc_q <= 32'h0;
         excess_q <= 1'b0;
         clean_secs_q <= 4'h0;
      end
      else
      begin
         loss_cyc_q <= loss_q ? ((loss_cyc_q < 32'(LOSS_ALARM_CYC)) ?
                       32'(loss_cyc_q + 32'h1) : loss_cyc_q) : 32'h0;
         if (loss_q && loss_cyc_q >= 32'(LOSS_ALARM_CYC - 1))
            excess_q <= 1'b1;
         if (sec_tick)
            clean_secs_q <= (sec_err || loss_q) ? 4'h0 : (clean_secs_q < 4'(`CLEAN_SECS) ?
                            4'(clean_secs_q + 4'h1) : clean_secs_q);
         if (excess_q && !loss_q && clean_secs_q == 4'(`CLEAN_SECS))
            excess_q <= 1'b0;
      end

   // Per-second classification
   assign sec_err = defects_q != 16'h0 || (play_valid && play_filler);
   assign sec_severe = thr_q[15:0] != 16'h0 &&
      16'(defects_q + 16'(play_valid && play_filler)) >= thr_q[15:0];
   assign uas_enter = !uas_q && sec_severe && ses_run_q == 4'(`UAS_RUN - 1);
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         defects_q <= 16'h0;
         es_q <= 16'h0;
         ses_q <= 16'h0;
         uas_cnt_q <= 16'h0;
         uas_q <= 1'b0;
         ses_run_q <= 4'h0;
         ok_run_q <= 4'h0;
      end
      else if (sec_tick)
      begin
         defects_q <= 16'h0;
         if (sec_err)
            es_q <= 16'(es_q + 16'h1);
         if (sec_severe)
            ses_q <= 16'(ses_q + 16'h1);
         ses_run_q <= sec_severe ? ((ses_run_q < 4'(`UAS_RUN)) ? 4'(ses_run_q + 4'h1) :
                      ses_run_q) : 4'h0;
         ok_run_q <= sec_severe ? 4'h0 : 4'(ok_run_q + 4'h1);
         if (uas_enter)
         begin
            uas_q <= 1'b1;
            uas_cnt_q <= 16'(uas_cnt_q + 16'(`UAS_RUN));
         end
         else if (uas_q && !sec_severe && ok_run_q == 4'(`UAS_RUN - 1))
         begin
            uas_q <= 1'b0;
            ok_run_q <= 4'h0;
         end
         else if (uas_q)
            uas_cnt_q <= 16'(uas_cnt_q + 16'h1);
      end
      else if (play_valid && play_filler && defects_q != 16'hFFFF)
         defects_q <= 16'(defects_q + 16'h1);

   // Misorder count and interval statistics
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         misord_q <= 16'h0;
         int_lost_q <= 16'h0;
         int_secs_q <= 16'h0;
         int_sec_q <= 10'h0;
      end
      else
      begin
         if (pkt_misord_drop && !pkt_stray)
            misord_q <= 16'(misord_q + 16'h1);
         if (sec_tick && int_sec_q == 10'(`INTERVAL_SECS - 1))
         begin
            int_sec_q <= 10'h0;
            int_lost_q <= 16'(pkt_expected && pkt_missing && !pkt_stray);
            int_secs_q <= 16'h0;
         end
         else
         begin
            if (sec_tick)
            begin
               int_sec_q <= 10'(int_sec_q + 10'h1);
               int_secs_q <= 16'(int_secs_q + 16'(loss_q));
            end
            if (pkt_expected && pkt_missing && !pkt_stray)
               int_lost_q <= 16'(int_lost_q + 16'h1);
         end
      end
   assign hist.close = sec_tick && int_sec_q == 10'(`INTERVAL_SECS - 1);
   assign hist.lost = int_lost_q;
   assign hist.secs = 16'(int_secs_q + 16'(loss_q));
   assign hist.sel = hist_sel_q;

   // TDM output path and remote-failure bit
   assign dl_force = ctrl_q[`CTRL_ESF] && play_dl_bit &&
      (loss_q || (play_valid && play_filler));
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         tdm_octet <= `ALL_ONES;
         tdm_valid <= 1'b0;
         tx_rbit <= 1'b0;
      end
      else
      begin
         tx_rbit <= loss_q;
         tdm_valid <= play_valid;
         if (pw_phase != 2'(pw_defect_monitor_pkg::PW_RUN))
            tdm_octet <= `ALL_ONES;
         else if (play_filler || loss_q)
         begin
            if (ctrl_q[`CTRL_AWARE] && !play_slot_mask[play_slot] && !loss_q)
               tdm_octet <= play_octet;
            else
               tdm_octet <= ctrl_q[`CTRL_AIS] ? `AIS_OCTET : fill_q[7:0];
         end
         else
            tdm_octet <= play_octet;
         if (dl_force)
            tdm_octet[`ESF_DL_BIT] <= 1'b1;
      end

   // Interrupt status; set wins over read clear
   assign irq_ev = {pkt_misord_drop && !pkt_stray, uas_enter && sec_tick,
                    excess_q == 1'b0 && loss_q && loss_cyc_q == 32'(LOSS_ALARM_CYC - 1),
                    loss_enter};
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         irq_stat_q <= 32'h0;
         irq <= 1'b0;
      end
      else
      begin
         irq_stat_q <= (rd_clear ? 32'h0 : irq_stat_q) | {28'h0, irq_ev};
         irq <= |(((rd_clear ? 32'h0 : irq_stat_q) | {28'h0, irq_ev}) & ~irq_mask_q);
      end

   chk_rbit_follows: assert property (@(posedge aclk) disable iff (!aresetn)
      loss_q |=> tx_rbit) else $error("remote bit missing in loss");
   chk_loss_enter: assert property (@(posedge aclk) disable iff (!aresetn)
      loss_enter |=> loss_q) else $error("loss state not entered");
   chk_excess_time: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(excess_q) |-> loss_cyc_q >= 32'(LOSS_ALARM_CYC - 1))
      else $error("excess alarm early");
   chk_excess_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(excess_q) |-> $past(clean_secs_q) == 4'(`CLEAN_SECS))
      else $error("excess alarm cleared early");
   chk_defect_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      sec_tick |=> defects_q == 16'h0) else $error("defects not cleared");
   chk_es_count: assert property (@(posedge aclk) disable iff (!aresetn)
      sec_tick && sec_err |=> es_q == 16'($past(es_q) + 16'h1))
      else $error("errored second missed");
   chk_fill_loss: assert property (@(posedge aclk) disable iff (!aresetn)
      loss_q && pw_phase == 2'(pw_defect_monitor_pkg::PW_RUN) && !ctrl_q[`CTRL_AIS] && !dl_force
      |=> tdm_octet == $past(fill_q[7:0])) else $error("fill not driven");
   chk_esf_ones: assert property (@(posedge aclk) disable iff (!aresetn)
      dl_force |=> tdm_octet[`ESF_DL_BIT]) else $error("data link bit not forced");
   chk_setup_ones: assert property (@(posedge aclk) disable iff (!aresetn)
      pw_phase != 2'(pw_defect_monitor_pkg::PW_RUN) |=> tdm_octet == `ALL_ONES)
      else $error("setup not all ones");
   chk_stray_stats: assert property (@(posedge aclk) disable iff (!aresetn)
      pkt_stray && !sec_tick |=> $stable(int_lost_q) && $stable(win_lost_q))
      else $error("stray changed statistics");
endmodule

/* File: pw_defect_monitor_params.svh */
// Purpose: constants for the pseudowire defect monitor
// Assumes: 20 MHz aclk, one-second tick from outside logic
// Notes: Behaviour list below
//
// Behaviour
// - Enter loss state on loss percentage or run
// - Set remote-failure bit while in loss state
// - Leave loss state on clean run or buffer
// - Excessive-loss alarm after 2.5 seconds in loss
// - Clear excessive-loss alarm after 10 clean seconds
// - Each filler played counts one error defect
// - Count errored, severe and unavailable seconds
// - Severe second when defects reach threshold
// - Unavailable after ten severe, until ten not
// - Drive fill value when data missing or loss
// - Structure-aware fill only in affected timeslots outside loss state
// - Fill octet configurable, resets to all ones
// - Force ESF data link bits to ones in loss
// - Count misordered packets that are discarded
// - Keep 96 intervals of loss statistics
// - Stray packets change no loss statistic
// - All ones toward port during setup, teardown
`ifndef PW_DEFECT_MONITOR_PARAMS_SVH
`define PW_DEFECT_MONITOR_PARAMS_SVH

`define REG_CTRL        12'h000
`define REG_WIN         12'h004
`define REG_THR         12'h008
`define REG_FILL        12'h00C
`define REG_STAT        12'h010
`define REG_IRQ_STAT    12'h014
`define REG_IRQ_MASK    12'h018
`define REG_ES          12'h01C
`define REG_SES         12'h020
`define REG_UAS         12'h024
`define REG_MISORD      12'h028
`define REG_HIST_SEL    12'h02C
`define REG_HIST_LOST   12'h030
`define REG_HIST_SECS   12'h034

`define CTRL_AWARE      0
`define CTRL_ESF        1
`define CTRL_AIS        2

`define FILL_RESET      8'hFF
`define AIS_OCTET       8'hFF
`define ALL_ONES        8'hFF
`define ESF_DL_BIT      7

`define LOSS_ALARM_MS   2500
`define CLEAN_SECS      10
`define UAS_RUN         10
`define HIST_DEPTH      96
`define INTERVAL_SECS   900

`define IRQ_LOSS        0
`define IRQ_EXCESS      1
`define IRQ_UAS         2
`define IRQ_MISORD      3

`endif

/* File: pw_defect_monitor_pkg.sv */
// Purpose: types for the pseudowire defect monitor
// Assumes: nothing
// Notes: none
package pw_defect_monitor_pkg;
   typedef enum logic [1:0] {PW_IDLE, PW_SETUP, PW_RUN, PW_TEARDOWN} pw_phase_t;
endpackage

/* File: hist_if.sv */
// Purpose: carries interval close events to the history store
// Assumes: one clock
// Notes: none
`timescale 1ns/1ns
interface hist_if;
   logic        close;
   logic [15:0] lost;
   logic [15:0] secs;
   logic [6:0]  sel;
   logic [15:0] rd_lost;
   logic [15:0] rd_secs;
   modport src (output close, output lost, output secs, output sel,
                input rd_lost, input rd_secs);
   modport dst (input close, input lost, input secs, input sel,
                output rd_lost, output rd_secs);
endinterface

/* File: loss_history.sv */
// Purpose: ring of interval loss statistics
// Assumes: close is a single-cycle pulse
// Notes: sel 0 is the newest closed interval
`timescale 1ns/1ns
`include "pw_defect_monitor_params.svh"
module loss_history #(
   parameter int DEPTH = `HIST_DEPTH
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   hist_if.dst       h
);
   logic [15:0] lost_mem [DEPTH];
   logic [15:0] secs_mem [DEPTH];
   logic [6:0]  wr_q;
   logic [6:0]  newest;
   logic [6:0]  idx;

   always_ff @(posedge aclk)
      if (!aresetn)
         wr_q <= 7'h00;
      else if (h.close)
         wr_q <= (wr_q == 7'(DEPTH - 1)) ? 7'h00 : 7'(wr_q + 7'h01);

   always_ff @(posedge aclk)
      if (h.close)
      begin
         lost_mem[wr_q] <= h.lost;
         secs_mem[wr_q] <= h.secs;
      end

   always_comb
   begin
      newest = (wr_q == 7'h00) ? 7'(DEPTH - 1) : 7'(wr_q - 7'h01);
      idx = (h.sel > newest) ? 7'(newest + 7'(DEPTH) - h.sel) : 7'(newest - h.sel);
      if (h.sel >= 7'(DEPTH))
         idx = newest;
   end

   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         h.rd_lost <= 16'h0000;
         h.rd_secs <= 16'h0000;
      end
      else
      begin
         h.rd_lost <= lost_mem[idx];
         h.rd_secs <= secs_mem[idx];
      end
endmodule

/* File: pw_peer.sv */
// Purpose: packet peer and jitter buffer playout model
// Assumes: one packet slot every second cycle
// Notes: idle lines toggle so stale values never look valid
`timescale 1ns/1ns
module pw_peer (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       go,
   input  wire logic [3:0] n,
   input  wire logic       lose,
   input  wire logic       stray,
   output logic            pkt_expected,
   output logic            pkt_missing,
   output logic            pkt_stray,
   output logic            play_valid,
   output logic            play_filler,
   output logic [7:0]      play_octet,
   output logic            busy
);
   logic [3:0] left_q;
   logic       lose_q;
   logic       stray_q;
   logic       tog_q;
   assign busy = (left_q != 4'h0);
   always @(posedge aclk)
   begin
      tog_q        <= ~tog_q;
      pkt_expected <= 1'h0;
      pkt_stray    <= 1'h0;
      play_valid   <= 1'h0;
      pkt_missing  <= tog_q;
      play_filler  <= ~tog_q;
      play_octet   <= {8{tog_q}} ^ 8'h96;
      if (!aresetn)
      begin
         left_q <= 4'h0;
         tog_q  <= 1'h0;
      end
      else if (go)
      begin
         left_q  <= n;
         lose_q  <= lose;
         stray_q <= stray;
      end
      else if (busy && tog_q)
      begin
         left_q       <= left_q - 4'h1;
         pkt_expected <= 1'h1;
         pkt_missing  <= lose_q;
         pkt_stray    <= stray_q;
         play_valid   <= !stray_q;
         play_filler  <= lose_q;
         play_octet   <= lose_q ? 8'h00 : 8'h3C;
      end
   end
endmodule

/* File: pw_defect_monitor_test.sv */
// Purpose: register level test of the defect monitor
// Assumes: peer model supplies packets and playout
// Notes: alarm count shortened to 20 cycles
`timescale 1ns/1ns
`include "pw_defect_monitor_params.svh"
module pw_defect_monitor_test;
   logic        aclk = 1'h0;
   logic        aresetn = 1'h0;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic        arvalid = 1'h0, rready = 1'h0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, rr, phase = 2'h0;
   logic        sec_tick = 1'h0, misord = 1'h0, go = 1'h0;
   logic        lose = 1'h0, stray = 1'h0;
   logic        clean = 1'h0, dl = 1'h0;
   logic [31:0] smask = 32'h0;
   logic [3:0]  npk = 4'h0;
   logic        pexp, pmiss, pstray, pvalid, pfill, busy;
   logic [7:0]  poct, tdm_octet, last_out = 8'h00;
   logic        tdm_valid, tx_rbit, irq;
   logic [1:0]  ph [2];
   int          miscompares = 0, comparisons = 0;

   initial forever #25 aclk = ~aclk;
   always @(posedge aclk) if (tdm_valid === 1'h1) last_out <= tdm_octet;

   pw_defect_monitor #(.LOSS_ALARM_CYC(20)) dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sec_tick(sec_tick),
      .pkt_expected(pexp), .pkt_missing(pmiss), .pkt_stray(pstray),
      .pkt_misord_drop(misord), .play_valid(pvalid), .play_filler(pfill),
      .buffer_clean(clean), .play_octet(poct), .play_slot_mask(smask),
      .play_slot(5'h0), .play_dl_bit(dl), .pw_phase(phase),
      .tdm_octet(tdm_octet), .tdm_valid(tdm_valid), .tx_rbit(tx_rbit), .irq(irq));

   pw_peer peer (
      .aclk(aclk), .aresetn(aresetn), .go(go), .n(npk), .lose(lose), .stray(stray),
      .pkt_expected(pexp), .pkt_missing(pmiss), .pkt_stray(pstray),
      .play_valid(pvalid), .play_filler(pfill), .play_octet(poct), .busy(busy));

   task automatic report_and_stop;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         $display("FAIL %s expected %h seen %h", what, exp, seen);
         miscompares++;
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      int k;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (k = 0; k < 100; k++)
      begin
         @(posedge aclk);
         if (awready === 1'h1) awvalid <= 1'h0;
         if (wready === 1'h1) wvalid <= 1'h0;
         if (bvalid === 1'h1) break;
      end
      bready <= 1'h0;
      check("bresp", {30'h0, bresp}, 32'h0);
      if (k == 100) check("write timeout", 32'h1, 32'h0);
      if (k == 100) report_and_stop();
   endtask

   task automatic rd_reg(input logic [11:0] a);
      int k;
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (k = 0; k < 100; k++)
      begin
         @(posedge aclk);
         if (arready === 1'h1) arvalid <= 1'h0;
         if (rvalid === 1'h1) break;
      end
      rd = rdata;
      rr = rresp;
      rready <= 1'h0;
      if (k == 100) check("read timeout", 32'h1, 32'h0);
      if (k == 100) report_and_stop();
   endtask

   task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
      rd_reg(a);
      check(what, rd, exp);
   endtask

   task automatic pkts(input logic [3:0] n, input logic l, input logic s);
      int k;
      go <= 1'h1;
      npk <= n;
      lose <= l;
      stray <= s;
      @(posedge aclk);
      go <= 1'h0;
      for (k = 0; k < 100; k++)
      begin
         @(posedge aclk);
         if (busy === 1'h0) break;
      end
      if (k == 100) check("peer timeout", 32'h1, 32'h0);
      if (k == 100) report_and_stop();
      repeat (3) @(posedge aclk);
   endtask

   task automatic ticks(input int n);
      repeat (n)
      begin
         sec_tick <= 1'h1;
         @(posedge aclk);
         sec_tick <= 1'h0;
         repeat (3) @(posedge aclk);
      end
   endtask

   initial
   begin
      ph = '{pw_defect_monitor_pkg::PW_TEARDOWN, pw_defect_monitor_pkg::PW_SETUP};
      repeat (5) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      check("idle octet", {24'h0, tdm_octet}, 32'hFF);
      rchk("fill reset", `REG_FILL, 32'hFF);
      rchk("stat reset", `REG_STAT, 32'h0);
      rd_reg(12'h0F0);
      check("unmapped resp", {30'h0, rr}, 32'h2);
      wr(`REG_WIN, 32'h0364_0010);
      wr(`REG_THR, 32'h0004_0002);
      wr(`REG_FILL, 32'h5A);
      wr(`REG_IRQ_MASK, 32'hF);
      phase <= pw_defect_monitor_pkg::PW_RUN;
      // Strays never advance the miss run
      pkts(4'h3, 1'h1, 1'h1);
      pkts(4'h2, 1'h1, 1'h0);
      rchk("stray loss", `REG_STAT, 32'h0);
      pkts(4'h1, 1'h0, 1'h0);
      ticks(1);
      rchk("es", `REG_ES, 32'h1);
      rchk("ses", `REG_SES, 32'h1);
      // Loss entry, interrupt, alarm and exit
      pkts(4'h3, 1'h1, 1'h0);
      rchk("loss in", `REG_STAT, 32'h1);
      check("rbit on", {31'h0, tx_rbit}, 32'h1);
      check("fill out", {24'h0, last_out}, 32'h5A);
      check("irq masked", {31'h0, irq}, 32'h0);
      wr(`REG_IRQ_MASK, 32'h0);
      repeat (2) @(posedge aclk);
      check("irq on", {31'h0, irq}, 32'h1);
      rchk("irq stat", `REG_IRQ_STAT, 32'h1);
      repeat (2) @(posedge aclk);
      check("irq clear", {31'h0, irq}, 32'h0);
      repeat (30) @(posedge aclk);
      rchk("excess", `REG_STAT, 32'h3);
      pkts(4'h3, 1'h0, 1'h0);
      rchk("loss hold", `REG_STAT, 32'h3);
      pkts(4'h1, 1'h0, 1'h0);
      rchk("loss out", `REG_STAT, 32'h2);
      check("rbit off", {31'h0, tx_rbit}, 32'h0);
      ticks(10);
      rchk("excess hold", `REG_STAT, 32'h2);
      ticks(1);
      rchk("excess off", `REG_STAT, 32'h0);
      rchk("es two", `REG_ES, 32'h2);
      // Ten severe seconds in a row
      for (int i = 0; i < 10; i++)
      begin
         pkts(4'h2, 1'h1, 1'h0);
         pkts(4'h1, 1'h0, 1'h0);
         ticks(1);
         if (i == 8) rchk("uas not yet", `REG_STAT, 32'h0);
      end
      rchk("uas on", `REG_STAT, 32'h4);
      rchk("uas ten", `REG_UAS, 32'hA);
      rchk("ses run", `REG_SES, 32'hC);
      ticks(9);
      rchk("uas hold", `REG_STAT, 32'h4);
      ticks(1);
      rchk("uas off", `REG_STAT, 32'h0);
      rchk("uas total", `REG_UAS, 32'h13);
      // Back-to-back discards
      misord <= 1'h1;
      repeat (2) @(posedge aclk);
      misord <= 1'h0;
      repeat (2) @(posedge aclk);
      rchk("misorder", `REG_MISORD, 32'h2);
      pkts(4'h3, 1'h1, 1'h0);
      clean <= 1'h1;
      pkts(4'h1, 1'h0, 1'h0);
      clean <= 1'h0;
      rchk("clean exit", `REG_STAT, 32'h0);
      wr(`REG_CTRL, 32'h1);
      pkts(4'h1, 1'h1, 1'h0);
      check("slot kept", {24'h0, last_out}, 32'h00);
      smask <= 32'h1;
      pkts(4'h1, 1'h1, 1'h0);
      check("slot filled", {24'h0, last_out}, 32'h5A);
      wr(`REG_CTRL, 32'h2);
      dl <= 1'h1;
      pkts(4'h1, 1'h0, 1'h0);
      check("dl clean", {24'h0, last_out}, 32'h3C);
      pkts(4'h1, 1'h1, 1'h0);
      check("dl forced", {24'h0, last_out}, 32'hDA);
      foreach (ph[i])
      begin
         phase <= pw_defect_monitor_pkg::PW_RUN;
         pkts(4'h1, 1'h0, 1'h0);
         check("data out", {24'h0, last_out}, 32'h3C);
         phase <= ph[i];
         pkts(4'h1, 1'h0, 1'h0);
         check("phase ones", {24'h0, last_out}, 32'hFF);
      end
      pkts(4'h3, 1'h1, 1'h0);
      ticks(868);
      rchk("hist lost", `REG_HIST_LOST, 32'h22);
      rchk("hist secs", `REG_HIST_SECS, 32'h364);
      report_and_stop();
   end
endmodule
